// [hw/uart_dtr_dsr_defines.vh]
`ifndef UART_DTR_DSR_DEFINES_VH
`define UART_DTR_DSR_DEFINES_VH
// ****************************************
// clock and bit rates
// ****************************************
`define CLK_FREQ_HZ 40000000
`define BAUD_300 300
`define BAUD_600 600
`define BAUD_1200 1200
`define BAUD_2400 2400
`define BAUD_4800 4800
`define BAUD_9600 9600
`define BAUD_SEL_300 3'h0
`define BAUD_SEL_600 3'h1
`define BAUD_SEL_1200 3'h2
`define BAUD_SEL_2400 3'h3
`define BAUD_SEL_4800 3'h4
`define BAUD_SEL_9600 3'h5
`define BAUD_SEL_RESET 3'h5
// ****************************************
// character format
// ****************************************
`define PAR_NONE 2'h0
`define PAR_ODD 2'h1
`define PAR_EVEN 2'h2
`define PAR_RESET 2'h0
`define FRAME_LAST_BIT 4'ha
`define STOP_MARKS 2'h3
`define CHAR_CTRL_C 8'h03
`define CHAR_NEWLINE 8'h0a
// ****************************************
// buffers
// ****************************************
`define RX_DEPTH 128
`define RX_COUNT_MAX 8'h80
`define RX_FULL_LEVEL 8'h64
`define TX_DEPTH 16
`define TX_COUNT_MAX 5'h10
// ****************************************
// register map, byte offsets
// ****************************************
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_RXDATA 8'h08
`define REG_TXDATA 8'h0c
`define REG_CMD 8'h10
// status / command bit positions
`define ST_ABORT 7
`define ST_PERR 8
`define ST_FERR 9
`define ST_OVR 10
`define CMD_QUERY 0
`define CMD_RESP_DONE 1
`endif

// [hw/uart_frame_tx.v]
`timescale 1ns/10ps
// ****************************************
// character transmitter, 11-bit frame
// ****************************************
module uart_frame_tx (
	// clock and reset
	input wire clk_sys_i,
	input wire resetn_i,
	// settings
	input wire [17:0] bit_cyc_i,
	input wire [1:0] par_mode_i,
	// character in
	input wire start_i,
	input wire [7:0] data_i,
	output reg busy_o,
	// line
	output reg txd_o
);
`include "uart_dtr_dsr_defines.vh"
	reg [9:0] sh_q; // payload then two stop marks
	reg [17:0] cnt_q; // cycles left in current bit
	reg [3:0] idx_q; // bits sent after start
	wire par_on = (par_mode_i == `PAR_ODD) || (par_mode_i == `PAR_EVEN);
	// parity over seven data bits, odd inverts
	wire par_bit = (^data_i[6:0]) ^ (par_mode_i == `PAR_ODD);
	wire [7:0] payload = par_on ? {par_bit, data_i[6:0]} : data_i;

	// bit timer and shifter; idle line stays at mark
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sh_q <= 10'h3ff;
			cnt_q <= 18'h00000;
			idx_q <= 4'h0;
			busy_o <= 1'b0;
			txd_o <= 1'b1;
		end else if (!busy_o) begin
			if (start_i) begin
				sh_q <= {`STOP_MARKS, payload};
				txd_o <= 1'b0; // start bit at space
				cnt_q <= bit_cyc_i - 18'h00001;
				idx_q <= 4'h0;
				busy_o <= 1'b1;
			end
		end else if (cnt_q != 18'h00000) begin
			cnt_q <= cnt_q - 18'h00001;
		end else if (idx_q == `FRAME_LAST_BIT) begin
			// second stop bit done
			busy_o <= 1'b0;
			txd_o <= 1'b1;
		end else begin
			txd_o <= sh_q[0]; // lsb first
			sh_q <= {1'b1, sh_q[9:1]};
			idx_q <= idx_q + 4'h1;
			cnt_q <= bit_cyc_i - 18'h00001;
		end
	end
endmodule

// [hw/uart_frame_rx.v]
`timescale 1ns/10ps
// ****************************************
// character receiver, 11-bit frame
// ****************************************
module uart_frame_rx (
	// clock and reset
	input wire clk_sys_i,
	input wire resetn_i,
	// settings
	input wire [17:0] bit_cyc_i,
	input wire [1:0] par_mode_i,
	// line, already synchronised
	input wire rxd_i,
	// character out
	output reg valid_o,
	output reg [7:0] data_o,
	output reg perr_o,
	output reg ferr_o
);
`include "uart_dtr_dsr_defines.vh"
	localparam S_IDLE = 2'b01;
	localparam S_RUN = 2'b10;
	reg [1:0] st_q; // one-hot state
	reg [17:0] cnt_q; // cycles to next sample
	reg [3:0] idx_q; // sample index, 0 is start
	reg [9:0] sh_q; // payload and stops
	wire [9:0] full = {rxd_i, sh_q[9:1]};
	wire par_on = (par_mode_i == `PAR_ODD) || (par_mode_i == `PAR_EVEN);

	// samples at mid-bit; a start shorter than half a bit is dropped
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_q <= S_IDLE;
			cnt_q <= 18'h00000;
			idx_q <= 4'h0;
			sh_q <= 10'h000;
			valid_o <= 1'b0;
			data_o <= 8'h00;
			perr_o <= 1'b0;
			ferr_o <= 1'b0;
		end else begin
			valid_o <= 1'b0;
			case (st_q)
			S_IDLE: begin
				if (!rxd_i) begin
					st_q <= S_RUN;
					cnt_q <= {1'b0, bit_cyc_i[17:1]};
					idx_q <= 4'h0;
				end
			end
			S_RUN: begin
				if (cnt_q != 18'h00000) begin
					cnt_q <= cnt_q - 18'h00001;
				end else if (idx_q == 4'h0 && rxd_i) begin
					st_q <= S_IDLE; // glitch, not a start
				end else if (idx_q == `FRAME_LAST_BIT) begin
					st_q <= S_IDLE;
					valid_o <= 1'b1;
					// seven bits with bit 7 cleared, or eight bits
					data_o <= par_on ? {1'b0, full[6:0]} : full[7:0];
					perr_o <= par_on && ((^full[7:0]) != (par_mode_i == `PAR_ODD));
					ferr_o <= full[9:8] != `STOP_MARKS;
				end else begin
					if (idx_q != 4'h0) begin
						sh_q <= full; // lsb first
					end
					idx_q <= idx_q + 4'h1;
					cnt_q <= bit_cyc_i - 18'h00001;
				end
			end
			default: begin
				st_q <= S_IDLE;
			end
			endcase
		end
	end
endmodule

// [hw/uart_dtr_dsr_flow_control.v]
`timescale 1ns/10ps
`include "uart_dtr_dsr_defines.vh"
// ****************************************
// serial port with dtr/dsr handshake
// ****************************************
// How it works
// - six bit rates, 9600 at reset
// - none/8, odd/7 or even/7 characters
// - one start bit, two stop bits
// - start, data, optional parity, two stops
// - settings survive device clear; power-on only
// - dtr is hold-off out, dsr permission in
// - dtr false when receive buffer holds 100
// - dtr false until query response sent
// - dsr checked before every outgoing character
// - dtr false while output suspended
// - ctrl-c aborts and drops pending output
module uart_dtr_dsr_flow_control #(
	parameter CLK_HZ = `CLK_FREQ_HZ
) (
	// clock and reset
	input wire clk_sys_i,
	input wire resetn_i,
	// ahb-lite slave
	input wire hsel_i,
	input wire [31:0] haddr_i,
	input wire [1:0] htrans_i,
	input wire hwrite_i,
	input wire [2:0] hsize_i,
	input wire [31:0] hwdata_i,
	input wire hready_i,
	output reg [31:0] hrdata_o,
	output reg hreadyout_o,
	output reg hresp_o,
	// serial pins
	input wire rxd_i,
	input wire dsr_i,
	output wire txd_o,
	output reg dtr_o
);
	// the header sits above the module so the clock default is known in the parameter list
	// ****************************************
	// bit period per rate
	// ****************************************
	localparam integer DIV_300 = CLK_HZ / `BAUD_300;
	localparam integer DIV_600 = CLK_HZ / `BAUD_600;
	localparam integer DIV_1200 = CLK_HZ / `BAUD_1200;
	localparam integer DIV_2400 = CLK_HZ / `BAUD_2400;
	localparam integer DIV_4800 = CLK_HZ / `BAUD_4800;
	localparam integer DIV_9600 = CLK_HZ / `BAUD_9600;

	reg [2:0] baud_sel_q; // rate select
	reg [1:0] par_mode_q; // parity select
	reg [17:0] bit_cyc; // clocks per bit

	// unused select codes fall back to the fastest rate
	always @* begin
		case (baud_sel_q)
		`BAUD_SEL_300: bit_cyc = DIV_300[17:0];
		`BAUD_SEL_600: bit_cyc = DIV_600[17:0];
		`BAUD_SEL_1200: bit_cyc = DIV_1200[17:0];
		`BAUD_SEL_2400: bit_cyc = DIV_2400[17:0];
		`BAUD_SEL_4800: bit_cyc = DIV_4800[17:0];
		default: bit_cyc = DIV_9600[17:0];
		endcase
	end

	// ****************************************
	// pin synchronisers
	// ****************************************
	reg [1:0] rxd_sync_q; // [0] feeds only [1]
	reg [1:0] dsr_sync_q; // [0] feeds only [1]
	wire rxd_s = rxd_sync_q[1];
	wire dsr_s = dsr_sync_q[1]; // high means transmit allowed

	// two flops on each asynchronous pin
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rxd_sync_q <= 2'h3;
			dsr_sync_q <= 2'h0;
		end else begin
			rxd_sync_q <= {rxd_sync_q[0], rxd_i};
			dsr_sync_q <= {dsr_sync_q[0], dsr_i};
		end
	end

	// ****************************************
	// framers
	// ****************************************
	wire rx_valid; // one-cycle received character
	wire [7:0] rx_data;
	wire rx_perr;
	wire rx_ferr;
	wire tx_busy;
	wire tx_start;
	wire [7:0] tx_head;

	uart_frame_rx uart_frame_rx_inst (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.bit_cyc_i(bit_cyc),
		.par_mode_i(par_mode_q),
		.rxd_i(rxd_s),
		.valid_o(rx_valid),
		.data_o(rx_data),
		.perr_o(rx_perr),
		.ferr_o(rx_ferr)
	);

	uart_frame_tx uart_frame_tx_inst (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.bit_cyc_i(bit_cyc),
		.par_mode_i(par_mode_q),
		.start_i(tx_start),
		.data_i(tx_head),
		.busy_o(tx_busy),
		.txd_o(txd_o)
	);

	// ctrl-c never enters the buffer; it clears the device instead
	wire abort = rx_valid && (rx_data == `CHAR_CTRL_C);
	wire rx_nl = rx_valid && (rx_data == `CHAR_NEWLINE);

	// ****************************************
	// ahb-lite decode
	// ****************************************
	wire accept = hsel_i && hready_i && htrans_i[1];
	wire rd_acc = accept && !hwrite_i;
	reg wr_pend_q; // write data phase pending
	reg [7:0] wr_addr_q; // its offset
	wire wr_ctrl = wr_pend_q && (wr_addr_q == `REG_CTRL);
	wire wr_stat = wr_pend_q && (wr_addr_q == `REG_STATUS);
	wire wr_tx = wr_pend_q && (wr_addr_q == `REG_TXDATA);
	wire wr_cmd = wr_pend_q && (wr_addr_q == `REG_CMD);

	// ****************************************
	// receive buffer
	// ****************************************
	reg [7:0] rx_mem [0:`RX_DEPTH-1]; // characters awaiting software
	reg [6:0] rx_wp_q;
	reg [6:0] rx_rp_q;
	reg [7:0] rx_cnt_q;
	wire rx_empty = rx_cnt_q == 8'h00;
	wire rx_push = rx_valid && !abort && (rx_cnt_q != `RX_COUNT_MAX);
	wire rx_pop = rd_acc && (haddr_i[7:0] == `REG_RXDATA) && !rx_empty;
	wire rx_full = rx_cnt_q >= `RX_FULL_LEVEL; // hold-off level

	// a read of the data register pops one character
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_wp_q <= 7'h00;
			rx_rp_q <= 7'h00;
			rx_cnt_q <= 8'h00;
		end else begin
			if (rx_push) begin
				rx_wp_q <= rx_wp_q + 7'h01;
			end
			if (rx_pop) begin
				rx_rp_q <= rx_rp_q + 7'h01;
			end
			if (rx_push && !rx_pop) begin
				rx_cnt_q <= rx_cnt_q + 8'h01;
			end else if (rx_pop && !rx_push) begin
				rx_cnt_q <= rx_cnt_q - 8'h01;
			end
		end
	end

	// storage without reset keeps it a plain memory
	always @(posedge clk_sys_i) begin
		if (rx_push) begin
			rx_mem[rx_wp_q] <= rx_data;
		end
	end

	// ****************************************
	// pending output queue
	// ****************************************
	reg [7:0] tx_mem [0:`TX_DEPTH-1]; // output not yet framed
	reg [3:0] tx_wp_q;
	reg [3:0] tx_rp_q;
	reg [4:0] tx_cnt_q;
	wire tx_have = tx_cnt_q != 5'h00;
	wire tx_push = wr_tx && !abort && (tx_cnt_q != `TX_COUNT_MAX);
	// dsr is looked at before each character only
	assign tx_start = tx_have && !tx_busy && dsr_s && !abort;
	assign tx_head = tx_mem[tx_rp_q];
	// a character waits on dsr
	wire suspended = tx_have && !tx_busy && !dsr_s;

	// an abort empties the queue; a frame on the wire still completes
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tx_wp_q <= 4'h0;
			tx_rp_q <= 4'h0;
			tx_cnt_q <= 5'h00;
		end else if (abort) begin
			tx_rp_q <= tx_wp_q;
			tx_cnt_q <= 5'h00;
		end else begin
			if (tx_push) begin
				tx_wp_q <= tx_wp_q + 4'h1;
			end
			if (tx_start) begin
				tx_rp_q <= tx_rp_q + 4'h1;
			end
			if (tx_push && !tx_start) begin
				tx_cnt_q <= tx_cnt_q + 5'h01;
			end else if (tx_start && !tx_push) begin
				tx_cnt_q <= tx_cnt_q - 5'h01;
			end
		end
	end

	// queue storage
	always @(posedge clk_sys_i) begin
		if (tx_push) begin
			tx_mem[tx_wp_q] <= hwdata_i[7:0];
		end
	end

	// ****************************************
	// query hold-off
	// ****************************************
	reg query_q; // software has a reply to give
	reg resp_done_q; // whole reply is queued
	reg nl_seen_q; // terminator received
	wire hold_query = query_q && nl_seen_q;
	wire drained = !tx_have && !tx_busy;
	wire release_q = query_q && resp_done_q && drained;

	// hold lasts until the last stop bit of the reply
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			query_q <= 1'b0;
			resp_done_q <= 1'b0;
			nl_seen_q <= 1'b0;
		end else if (abort || release_q) begin
			query_q <= 1'b0;
			resp_done_q <= 1'b0;
			nl_seen_q <= 1'b0;
		end else begin
			if (wr_cmd && hwdata_i[`CMD_QUERY]) begin
				query_q <= 1'b1;
			end
			if (wr_cmd && hwdata_i[`CMD_RESP_DONE]) begin
				resp_done_q <= 1'b1;
			end
			if (rx_nl) begin
				nl_seen_q <= 1'b1;
			end
		end
	end

	// ****************************************
	// dtr output
	// ****************************************
	// any of three causes holds the host off
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dtr_o <= 1'b0;
		end else begin
			dtr_o <= !(rx_full || hold_query || suspended);
		end
	end

	// ****************************************
	// settings and sticky flags
	// ****************************************
	reg abort_q; // ctrl-c seen
	reg perr_q; // parity error seen
	reg ferr_q; // stop bit missing
	reg ovr_q; // character lost, buffer at capacity
	wire ovr_set = rx_valid && !abort && (rx_cnt_q == `RX_COUNT_MAX);

	// settings reset only at power-on; ctrl-c leaves them alone
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			baud_sel_q <= `BAUD_SEL_RESET;
			par_mode_q <= `PAR_RESET;
		end else if (wr_ctrl) begin
			baud_sel_q <= hwdata_i[2:0];
			par_mode_q <= hwdata_i[4:3];
		end
	end

	// write one to clear; a new event in the same cycle wins
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			abort_q <= 1'b0;
			perr_q <= 1'b0;
			ferr_q <= 1'b0;
			ovr_q <= 1'b0;
		end else begin
			abort_q <= abort || (abort_q && !(wr_stat && hwdata_i[`ST_ABORT]));
			perr_q <= (rx_valid && rx_perr) || (perr_q && !(wr_stat && hwdata_i[`ST_PERR]));
			ferr_q <= (rx_valid && rx_ferr) || (ferr_q && !(wr_stat && hwdata_i[`ST_FERR]));
			ovr_q <= ovr_set || (ovr_q && !(wr_stat && hwdata_i[`ST_OVR]));
		end
	end

	// ****************************************
	// bus answers
	// ****************************************
	reg [31:0] rd_mux;

	// read value built in the address phase
	always @* begin
		case (haddr_i[7:0])
		`REG_CTRL: rd_mux = {27'h0000000, par_mode_q, baud_sel_q};
		`REG_STATUS: rd_mux = {8'h00, rx_cnt_q, 4'h0, hold_query, ovr_q, ferr_q, perr_q,
			abort_q, dsr_s, dtr_o, suspended, tx_busy, !tx_have, rx_full, !rx_empty};
		`REG_RXDATA: rd_mux = {24'h000000, rx_empty ? 8'h00 : rx_mem[rx_rp_q]};
		`REG_CMD: rd_mux = {30'h00000000, resp_done_q, query_q};
		default: rd_mux = 32'h00000000;
		endcase
	end

	// zero wait states, always okay
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hrdata_o <= 32'h00000000;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
			wr_pend_q <= accept && hwrite_i;
			wr_addr_q <= haddr_i[7:0];
			if (rd_acc) begin
				hrdata_o <= rd_mux;
			end
		end
	end
endmodule

// [verif/uart_flow_asserts.sv]
`timescale 1ns/10ps
// ****************************************
// port checker for the serial block
// ****************************************
module uart_flow_asserts #(
	parameter CLK_HZ = 40000000
) (
	// clock and reset
	input wire clk_sys_i,
	input wire resetn_i,
	// bus
	input wire hsel_i,
	input wire [31:0] haddr_i,
	input wire [1:0] htrans_i,
	input wire hwrite_i,
	input wire [31:0] hwdata_i,
	input wire hready_i,
	input wire [31:0] hrdata_o,
	input wire hreadyout_o,
	input wire hresp_o,
	// serial pins
	input wire dsr_i,
	input wire txd_o,
	input wire dtr_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	reg wr_ctrl_q; // data phase of a rate/format write
	reg [4:0] ctrl_q; // shadow of rate and format, snooped from the bus
	reg act_q; // a frame is on the outgoing line
	reg [31:0] cnt_q; // cycles since the start bit began
	wire [31:0] bit_c; // cycles per bit for the shadowed rate
	wire addr_ph = hsel_i && hready_i && htrans_i[1];
	// rates double from 300 upwards; codes above 5 act as the top rate
	function automatic integer rate(input [2:0] s);
		rate = (s > 3'h5) ? 9600 : (300 << s);
	endfunction
	assign bit_c = CLK_HZ / rate(ctrl_q[2:0]);
	// shadow and frame tracker; the frame ends a cycle early to tolerate rounding
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_ctrl_q <= 1'b0;
			ctrl_q <= 5'h05;
			act_q <= 1'b0;
			cnt_q <= 32'h0;
		end else begin
			wr_ctrl_q <= addr_ph && hwrite_i && (haddr_i[7:0] == 8'h00);
			if (wr_ctrl_q) begin
				ctrl_q <= hwdata_i[4:0];
			end
			if (!act_q && $fell(txd_o)) begin
				act_q <= 1'b1;
				cnt_q <= 32'h1;
			end else if (act_q) begin
				cnt_q <= cnt_q + 32'h1;
				if (cnt_q >= 11 * bit_c - 2) begin
					act_q <= 1'b0;
				end
			end
		end
	end
	// ****************************************
	// properties
	// ****************************************
	sequence s_rd;
		addr_ph && !hwrite_i;
	endsequence
	sequence s_start;
		!act_q && $fell(txd_o);
	endsequence
	property p_ready;
		hreadyout_o;
	endproperty
	property p_okay;
		!hresp_o;
	endproperty
	property p_unmapped;
		s_rd ##0 (haddr_i[7:0] > 8'h13) |=> hrdata_o == 32'h0;
	endproperty
	property p_ctrl_rb;
		s_rd ##0 (haddr_i[7:0] == 8'h00) |=> hrdata_o == {27'h0, $past(ctrl_q)};
	endproperty
	property p_start_space;
		act_q && (cnt_q == bit_c / 2) |-> !txd_o;
	endproperty
	property p_stop_marks;
		act_q && (cnt_q == 9 * bit_c + bit_c / 2 || cnt_q == 10 * bit_c + bit_c / 2) |-> txd_o;
	endproperty
	property p_no_start;
		(!dsr_i) [*6] |=> not s_start;
	endproperty
	property p_dtr_up;
		$rose(resetn_i) |-> ##[0:3] dtr_o;
	endproperty
	a_ready: assert property (p_ready)
		else $error("bus ready dropped");
	a_okay: assert property (p_okay)
		else $error("bus error response");
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	a_ctrl_rb: assert property (p_ctrl_rb)
		else $error("rate and format readback wrong");
	a_start_space: assert property (p_start_space)
		else $error("start bit not space");
	a_stop_marks: assert property (p_stop_marks)
		else $error("stop bits not mark");
	a_no_start: assert property (p_no_start)
		else $error("frame started while permission low");
	a_dtr_up: assert property (p_dtr_up)
		else $error("hold-off not released after reset");
endmodule
bind uart_dtr_dsr_flow_control uart_flow_asserts #(.CLK_HZ(CLK_HZ)) uart_flow_asserts_inst (
	.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
	.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
	.hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .dsr_i(dsr_i),
	.txd_o(txd_o), .dtr_o(dtr_o)
);

// [verif/host_term_model.sv]
`timescale 1ns/10ps
// ****************************************
// far-side terminal: frames characters both ways, drives permission
// ****************************************
module host_term_model (
	// clock
	input wire clk_sys_i,
	// lines from the device
	input wire txd_i,
	input wire dtr_i,
	// lines to the device
	output reg rxd_o,
	output reg dsr_o
);
	initial begin
		rxd_o = 1'b1; // idle at mark
		dsr_o = 1'b1; // permission true unless a scenario drops it
	end
	// payload byte: eight data bits, or seven plus odd/even parity in bit 7
	function automatic [7:0] pay(input [7:0] c, input [1:0] p);
		pay = (p == 2'h0) ? c : {(p == 2'h1) ? ~^c[6:0] : ^c[6:0], c[6:0]};
	endfunction
	// one frame out; waits for hold-off to clear unless told to push through
	task automatic send(input [7:0] c, input integer bitc, input [1:0] p, input reg wt);
		reg [10:0] f;
		integer i;
		integer n;
		begin
			f = {2'b11, pay(c, p), 1'b0};
			n = 0;
			while (wt && dtr_i !== 1'b1 && n < 100000) begin
				@(posedge clk_sys_i);
				n = n + 1;
			end
			for (i = 0; i < 11; i = i + 1) begin
				rxd_o <= f[i]; // lsb first
				repeat (bitc) @(posedge clk_sys_i);
			end
		end
	endtask
	// one frame in, sampled at bit centres; ok means start space and two marks
	task automatic recv(input integer bitc, output [7:0] b, output reg ok);
		reg [9:0] sh;
		integer i;
		integer n;
		begin
			n = 0;
			while (txd_i !== 1'b0 && n < 200000) begin
				@(posedge clk_sys_i);
				n = n + 1;
			end
			repeat (bitc / 2) @(posedge clk_sys_i);
			ok = (txd_i === 1'b0) && (n < 200000);
			for (i = 0; i < 10; i = i + 1) begin
				repeat (bitc) @(posedge clk_sys_i);
				sh[i] = txd_i;
			end
			b = sh[7:0];
			ok = ok && (sh[9:8] === 2'b11);
		end
	endtask
endmodule

// [verif/uart_dtr_dsr_flow_control_tb.sv]
`timescale 1ns/10ps
`include "uart_dtr_dsr_defines.vh"
// ****************************************
// bench: bus tasks, host model, sequences of checks
// ****************************************
module uart_dtr_dsr_flow_control_tb;
	localparam CLK_HZ = 100000; // short bit times: 9600 gives 10 cycles
	reg clk_sys_i, resetn_i, hsel_i, hwrite_i;
	reg [31:0] haddr_i, hwdata_i;
	reg [1:0] htrans_i;
	reg [2:0] hsize_i;
	wire [31:0] hrdata_o;
	wire hreadyout_o, hresp_o, rxd_i, dsr_i, txd_o, dtr_o;
	integer err_total, checked, i, b;
	reg [31:0] r;
	reg [7:0] c, got;
	reg [1:0] p;
	reg ok;
	uart_dtr_dsr_flow_control #(.CLK_HZ(CLK_HZ)) uart_dtr_dsr_flow_control_inst (
		.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
		.hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
		.hresp_o(hresp_o), .rxd_i(rxd_i), .dsr_i(dsr_i), .txd_o(txd_o), .dtr_o(dtr_o));
	host_term_model host_term_model_inst (.clk_sys_i(clk_sys_i), .txd_i(txd_o),
		.dtr_i(dtr_o), .rxd_o(rxd_i), .dsr_o(dsr_i));
	initial begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			err_total = err_total + 1;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask
	task complete_run;
		$display("checks %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// one single transfer; entered just after a rising edge
	// no cycle count is assumed; only the watchdog ends a stuck wait
	task ahb(input reg w, input [7:0] a, input [31:0] d, output [31:0] rd);
		begin
			htrans_i <= 2'h2;
			haddr_i <= {24'h0, a};
			hwrite_i <= w;
			do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
			htrans_i <= 2'h0;
			hwdata_i <= d;
			do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
			rd = hrdata_o;
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		reg [31:0] x;
		ahb(1'b1, a, d, x);
	endtask
	// watch the outgoing line stay at mark for n cycles
	task quiet(input integer n);
		reg q;
		begin
			q = 1'b1;
			repeat (n) begin
				@(posedge clk_sys_i);
				if (txd_o !== 1'b1) q = 1'b0;
			end
			check("idle line", 32'(q), 32'h1);
		end
	endtask
	initial begin
		// tests need about 26000 cycles, mostly the slow rates and the 100-character fill
		repeat (60000) @(posedge clk_sys_i);
		err_total = err_total + 1;
		complete_run;
	end
	initial begin
		resetn_i = 1'b0; hsel_i = 1'b0; hwrite_i = 1'b0; haddr_i = 32'h0;
		hwdata_i = 32'h0; htrans_i = 2'h0; hsize_i = 3'h2; err_total = 0; checked = 0;
		repeat (6) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		hsel_i <= 1'b1;
		@(posedge clk_sys_i);
		ahb(1'b0, `REG_CTRL, 32'h0, r);
		check("reset format", r, 32'h05);
		check("dtr after reset", 32'(dtr_o), 32'h1);
		wr(8'h14, 32'hffffffff);
		ahb(1'b0, 8'h14, 32'h0, r);
		check("unmapped", r, 32'h0);
		// every rate once, formats in turn, one character each way
		for (i = 0; i < 6; i = i + 1) begin
			p = 2'(i % 3);
			b = CLK_HZ / (300 << i);
			c = 8'hc5 ^ 8'(i);
			wr(`REG_CTRL, {27'h0, p, 3'(i)});
			ahb(1'b0, `REG_CTRL, 32'h0, r);
			check("format", r, {27'h0, p, 3'(i)});
			wr(`REG_TXDATA, {24'h0, c});
			host_term_model_inst.recv(b, got, ok);
			check("tx payload", 32'(got), 32'(host_term_model_inst.pay(c, p)));
			check("tx frame", 32'(ok), 32'h1);
			host_term_model_inst.send(c ^ 8'h3c, b, p, 1'b1);
			repeat (4) @(posedge clk_sys_i);
			ahb(1'b0, `REG_RXDATA, 32'h0, r);
			check("rx char", r, 32'((c ^ 8'h3c) & ((p == 2'h0) ? 8'hff : 8'h7f)));
		end
		b = CLK_HZ / 9600;
		wr(`REG_CTRL, 32'h05);
		// output held while permission low, resumes when it returns
		host_term_model_inst.dsr_o <= 1'b0;
		repeat (8) @(posedge clk_sys_i);
		wr(`REG_TXDATA, 32'h5a);
		quiet(b * 15);
		check("dtr suspended", 32'(dtr_o), 32'h0);
		host_term_model_inst.dsr_o <= 1'b1;
		host_term_model_inst.recv(b, got, ok);
		check("resumed char", 32'(got), 32'h5a);
		// abort with pending output; host dropped permission first
		host_term_model_inst.dsr_o <= 1'b0;
		repeat (8) @(posedge clk_sys_i);
		wr(`REG_TXDATA, 32'ha5);
		host_term_model_inst.send(`CHAR_CTRL_C, b, 2'h0, 1'b0);
		repeat (4) @(posedge clk_sys_i);
		ahb(1'b0, `REG_STATUS, 32'h0, r);
		check("abort seen", 32'(r[7]), 32'h1);
		check("output dropped", 32'(r[2]), 32'h1);
		check("abort not stored", 32'(r[0]), 32'h0);
		host_term_model_inst.dsr_o <= 1'b1;
		quiet(b * 15);
		wr(`REG_STATUS, 32'h80);
		ahb(1'b0, `REG_STATUS, 32'h0, r);
		check("abort cleared", 32'(r[7]), 32'h0);
		// query: hold-off from newline until the reply is out
		wr(`REG_CMD, 32'h1);
		host_term_model_inst.send(`CHAR_NEWLINE, b, 2'h0, 1'b1);
		repeat (4) @(posedge clk_sys_i);
		check("query hold", 32'(dtr_o), 32'h0);
		ahb(1'b0, `REG_RXDATA, 32'h0, r);
		check("newline", r, 32'h0a);
		wr(`REG_TXDATA, 32'h4f);
		wr(`REG_CMD, 32'h3);
		host_term_model_inst.recv(b, got, ok);
		check("reply", 32'(got), 32'h4f);
		repeat (b * 3) @(posedge clk_sys_i);
		check("query release", 32'(dtr_o), 32'h1);
		wr(`REG_CMD, 32'h0);
		// receive buffer: hold-off at the hundredth character, release on a pop
		for (i = 0; i < 99; i = i + 1) host_term_model_inst.send(8'h41, b, 2'h0, 1'b1);
		repeat (4) @(posedge clk_sys_i);
		check("dtr at 99", 32'(dtr_o), 32'h1);
		ahb(1'b0, `REG_STATUS, 32'h0, r);
		check("count", 32'(r[23:16]), 32'd99);
		host_term_model_inst.send(8'h41, b, 2'h0, 1'b1);
		repeat (4) @(posedge clk_sys_i);
		check("dtr full", 32'(dtr_o), 32'h0);
		ahb(1'b0, `REG_RXDATA, 32'h0, r);
		check("pop", r, 32'h41);
		repeat (4) @(posedge clk_sys_i);
		check("dtr freed", 32'(dtr_o), 32'h1);
		complete_run;
	end
endmodule
